// ### bid_branch_decode.sv
// Notes on behaviour
// - Absolute call: two bytes, two cycles, eight opcodes by target bits 10..8.
// - Long call: three bytes with full 16-bit target, two cycles, one opcode.
// - Absolute jump/call: opcode bits 7..5 become target address bits 10..8.
// - Short relative jump: two bytes, two cycles, single opcode.
// - Jump if direct bit is one: three bytes, two cycles, bit untouched.
// - Jump if direct bit is zero: three bytes, two cycles, own opcode.
// - Jump if direct bit is one and clear that bit: three bytes, two cycles.
// - Indirect jump to accumulator plus data pointer: one byte, two cycles.
// - Relative jump when accumulator is zero: two bytes, two cycles.
// - Relative jump when accumulator is non-zero: two bytes, two cycles.
// - Compare accumulator with direct byte, jump if different: three bytes.
// - Compare accumulator with immediate, jump if different: three bytes.
// - Compare working register with immediate, low three bits pick register.
// - Compare indirect byte with immediate, lowest bit picks pointer register.
// - Decrement working register, jump if non-zero: two bytes, two cycles.
// - Decrement direct byte, jump if non-zero: three bytes, two cycles.
// - In eight-code blocks the low three opcode bits select the register.
// - Shared opcode is program store or software break by select field.
// - Program store writes accumulator at data pointer, then increments it.
// - Bit tests on changing input-port pins may misevaluate; internal bits safe.
`timescale 1ns/1ps
`include "bid_consts.svh"

module bid_branch_decode #(
  parameter int ADDR_W = 16,
  parameter int PORT_W = 8
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                start_i,
  input  wire logic [7:0]          opcode_i,
  input  wire logic [7:0]          opnd1_i,
  input  wire logic [7:0]          opnd2_i,
  input  wire logic [ADDR_W-1:0]   pc_i,
  input  wire logic [7:0]          acc_i,
  input  wire logic [ADDR_W-1:0]   dptr_i,
  input  wire logic                carry_i,
  input  wire logic [ADDR_W-1:0]   stack_word_i,
  input  wire logic [3:0]          extended_opcode_select_i,
  input  wire logic                bit_value_i,
  input  wire logic                bit_is_port_i,
  input  wire logic [7:0]          direct_byte_i,
  input  wire logic                direct_is_port_i,
  input  wire logic [7:0]          reg_value_i,
  input  wire logic [PORT_W-1:0]   port_pin_i,
  output logic                     busy_o,
  output logic                     done_o,
  output bid_pkg::bid_class_t      class_o,
  output logic                     branch_taken_o,
  output logic [ADDR_W-1:0]        next_pc_o,
  output logic [1:0]               inst_len_o,
  output logic [1:0]               cycles_o,
  output logic [2:0]               reg_sel_o,
  output logic                     push_ret_o,
  output logic [ADDR_W-1:0]        ret_addr_o,
  output logic                     pop_ret_o,
  output logic                     irq_done_o,
  output logic                     bit_clear_o,
  output logic                     carry_write_o,
  output logic                     carry_o,
  output logic                     dec_write_o,
  output logic [7:0]               dec_value_o,
  output logic                     code_write_o,
  output logic [ADDR_W-1:0]        code_addr_o,
  output logic [7:0]               code_data_o,
  output logic                     dptr_write_o,
  output logic [ADDR_W-1:0]        dptr_next_o,
  output logic                     trap_o
);

  import bid_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Absolute targets keep bits above 10 of the next address
  if (ADDR_W < 12) begin : g_bad_addr
    $error("bid_branch_decode: ADDR_W must be at least 12");
  end
  if (PORT_W != 8) begin : g_bad_port
    $error("bid_branch_decode: PORT_W must be 8");
  end

  // ----------------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------------
  // Register field of an eight-code block
  function automatic logic [2:0] reg_field(input logic [7:0] op);
    reg_field = op[2:0];
  endfunction : reg_field

  function automatic bid_class_t classify(input logic [7:0] op,
                                          input logic [3:0] eo);
    bid_class_t c;
    c = CL_NONE;
    if ((op & `BID_ABS_LOW_MASK) == `BID_ACALL_LOW) begin
      c = CL_ACALL;
    end else if ((op & `BID_ABS_LOW_MASK) == `BID_AJMP_LOW) begin
      c = CL_AJMP;
    end else if (op[7:3] == `BID_CJNE_R_HI) begin
      c = CL_CJNE_R;
    end else if (op[7:3] == `BID_DJNZ_R_HI) begin
      c = CL_DJNZ_R;
    end else if (op[7:1] == `BID_CJNE_IND_HI) begin
      c = CL_CJNE_IND;
    end else begin
      case (op)
        `BID_OP_NOP:     c = CL_NOP;
        `BID_OP_LCALL:   c = CL_LCALL;
        `BID_OP_RET:     c = CL_RET;
        `BID_OP_RETI:    c = CL_RETI;
        `BID_OP_LJMP:    c = CL_LJMP;
        `BID_OP_SJMP:    c = CL_SJMP;
        `BID_OP_JC:      c = CL_JC;
        `BID_OP_JNC:     c = CL_JNC;
        `BID_OP_JB:      c = CL_JB;
        `BID_OP_JNB:     c = CL_JNB;
        `BID_OP_JBC:     c = CL_JBC;
        `BID_OP_JMPI:    c = CL_JMPI;
        `BID_OP_JZ:      c = CL_JZ;
        `BID_OP_JNZ:     c = CL_JNZ;
        `BID_OP_CJNE_AD: c = CL_CJNE_AD;
        `BID_OP_CJNE_AI: c = CL_CJNE_AI;
        `BID_DJNZ_D:     c = CL_DJNZ_D;
        `BID_OP_EXT:     c = (eo == `BID_EO_STORE_SEL) ? CL_PSTORE : CL_TRAP;
        default:         c = CL_NONE;
      endcase
    end
    classify = c;
  endfunction : classify

  // Bytes taken by a class
  function automatic logic [1:0] length_of(input bid_class_t c);
    case (c)
      CL_LCALL, CL_LJMP, CL_JB, CL_JNB, CL_JBC, CL_CJNE_AD, CL_CJNE_AI,
      CL_CJNE_R, CL_CJNE_IND, CL_DJNZ_D:
        length_of = `BID_LEN_3;
      CL_ACALL, CL_AJMP, CL_SJMP, CL_JC, CL_JNC, CL_JZ, CL_JNZ, CL_DJNZ_R:
        length_of = `BID_LEN_2;
      default:
        length_of = `BID_LEN_1;
    endcase
  endfunction : length_of

  // Cycles taken by a class; unknown codes run as one-cycle no-ops
  function automatic logic [1:0] cycles_of(input bid_class_t c);
    case (c)
      CL_NONE, CL_NOP, CL_TRAP: cycles_of = `BID_CYC_1;
      default:                  cycles_of = `BID_CYC_2;
    endcase
  endfunction : cycles_of

  // ----------------------------------------------------------------------
  // Input port pin filter
  // ----------------------------------------------------------------------
  logic [PORT_W-1:0] pin_filt;

  bid_pin_filter #(
    .WIDTH (PORT_W)
  ) u_pin_filter (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (port_pin_i),
    .pin_o     (pin_filt)
  );

  // Port operands come from the filtered pins, four clocks behind the pad;
  // a pin that moves near the fetch can still be seen stale or fresh
  wire       bit_src    = bit_is_port_i ? pin_filt[opnd1_i[2:0]] : bit_value_i;
  wire [7:0] direct_src = direct_is_port_i ? pin_filt : direct_byte_i;

  // ----------------------------------------------------------------------
  // Decode of the incoming opcode
  // ----------------------------------------------------------------------
  wire bid_class_t in_class = classify(opcode_i, extended_opcode_select_i);
  wire [1:0]       in_cyc   = cycles_of(in_class);

  // ----------------------------------------------------------------------
  // Latched instruction
  // ----------------------------------------------------------------------
  bid_state_t        state;
  logic [1:0]        cnt;
  bid_class_t        cls;
  logic [7:0]        op;
  logic [7:0]        o1;
  logic [7:0]        o2;
  logic [ADDR_W-1:0] pc_q;
  logic [7:0]        acc_q;
  logic [ADDR_W-1:0] dptr_q;
  logic              carry_q;
  logic [ADDR_W-1:0] stack_q;
  logic              bit_q;
  logic [7:0]        direct_q;
  logic [7:0]        reg_q;

  wire take   = (state == ST_IDLE) && start_i;
  wire finish = (state == ST_RUN) && (cnt == 2'h0);

  // Operands are captured with the request so the core may move on
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cls      <= CL_NONE;
      op       <= 8'h00;
      o1       <= 8'h00;
      o2       <= 8'h00;
      pc_q     <= '0;
      acc_q    <= 8'h00;
      dptr_q   <= '0;
      carry_q  <= 1'b0;
      stack_q  <= '0;
      bit_q    <= 1'b0;
      direct_q <= 8'h00;
      reg_q    <= 8'h00;
    end else if (take) begin
      cls      <= in_class;
      op       <= opcode_i;
      o1       <= opnd1_i;
      o2       <= opnd2_i;
      pc_q     <= pc_i;
      acc_q    <= acc_i;
      dptr_q   <= dptr_i;
      carry_q  <= carry_i;
      stack_q  <= stack_word_i;
      bit_q    <= bit_src;
      direct_q <= direct_src;
      reg_q    <= reg_value_i;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cnt   <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_i) begin
            state <= ST_RUN;
            cnt   <= in_cyc - 2'h1;
          end
        end
        ST_RUN: begin
          if (cnt == 2'h0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Targets
  // ----------------------------------------------------------------------
  wire [1:0]        len      = length_of(cls);
  wire [ADDR_W-1:0] seq_pc   = pc_q + ADDR_W'(len);
  // Offset is the last byte of the instruction
  wire [7:0]        rel      = (len == `BID_LEN_3) ? o2 : o1;
  wire [ADDR_W-1:0] rel_tgt  = seq_pc + {{(ADDR_W-8){rel[7]}}, rel};
  wire [ADDR_W-1:0] abs_tgt  = {seq_pc[ADDR_W-1:11], op[7:5], o1};
  wire [ADDR_W-1:0] long_tgt = ADDR_W'({o1, o2});
  wire [ADDR_W-1:0] ind_tgt  = dptr_q + ADDR_W'(acc_q);

  // ----------------------------------------------------------------------
  // Compare and decrement
  // ----------------------------------------------------------------------
  // Left and right operands of the compare; carry means left below right
  wire [7:0] cmp_l  = (cls == CL_CJNE_R || cls == CL_CJNE_IND) ? reg_q : acc_q;
  wire [7:0] cmp_r  = (cls == CL_CJNE_AD) ? direct_q : o1;
  wire       cmp_ne = (cmp_l != cmp_r);
  wire       cmp_lt = (cmp_l < cmp_r);
  wire [7:0] dec_v  = ((cls == CL_DJNZ_D) ? direct_q : reg_q) - 8'h01;

  // ----------------------------------------------------------------------
  // Branch condition
  // ----------------------------------------------------------------------
  logic              taken;
  logic [ADDR_W-1:0] tgt;

  always_comb begin
    taken = 1'b0;
    tgt   = seq_pc;
    case (cls)
      CL_ACALL, CL_AJMP: begin
        taken = 1'b1;
        tgt   = abs_tgt;
      end
      CL_LCALL, CL_LJMP: begin
        taken = 1'b1;
        tgt   = long_tgt;
      end
      CL_RET, CL_RETI: begin
        taken = 1'b1;
        tgt   = stack_q;
      end
      CL_JMPI: begin
        taken = 1'b1;
        tgt   = ind_tgt;
      end
      CL_SJMP: begin
        taken = 1'b1;
        tgt   = rel_tgt;
      end
      CL_JC, CL_JNC, CL_JB, CL_JNB, CL_JBC, CL_JZ, CL_JNZ, CL_CJNE_AD,
      CL_CJNE_AI, CL_CJNE_R, CL_CJNE_IND, CL_DJNZ_R, CL_DJNZ_D: begin
        tgt = rel_tgt;
        case (cls)
          CL_JC:                  taken = carry_q;
          CL_JNC:                 taken = !carry_q;
          CL_JB, CL_JBC:          taken = bit_q;
          CL_JNB:                 taken = !bit_q;
          CL_JZ:                  taken = (acc_q == 8'h00);
          CL_JNZ:                 taken = (acc_q != 8'h00);
          CL_DJNZ_R, CL_DJNZ_D:   taken = (dec_v != 8'h00);
          default:                taken = cmp_ne;
        endcase
        // Untaken branches fall through to the next instruction
        if (!taken) begin
          tgt = seq_pc;
        end
      end
      default: begin
        taken = 1'b0;
        tgt   = seq_pc;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Side effects
  // ----------------------------------------------------------------------
  wire is_call   = (cls == CL_ACALL) || (cls == CL_LCALL);
  wire is_ret    = (cls == CL_RET) || (cls == CL_RETI);
  // Bit clear only when the test hit, so a zero bit is never rewritten
  wire clr_bit   = (cls == CL_JBC) && bit_q;
  wire is_cmp    = (cls == CL_CJNE_AD) || (cls == CL_CJNE_AI) ||
                   (cls == CL_CJNE_R) || (cls == CL_CJNE_IND);
  wire is_dec    = (cls == CL_DJNZ_R) || (cls == CL_DJNZ_D);
  wire is_store  = (cls == CL_PSTORE);
  wire [2:0] rsel = (cls == CL_CJNE_IND) ? {2'b00, op[0]} : reg_field(op);

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  // Status outputs follow the sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= take || (busy_o && !finish);
      done_o <= finish;
    end
  end

  // Results hold from one finish until the next
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      class_o        <= CL_NONE;
      branch_taken_o <= 1'b0;
      next_pc_o      <= '0;
      inst_len_o     <= 2'h0;
      cycles_o       <= 2'h0;
      reg_sel_o      <= 3'h0;
      ret_addr_o     <= '0;
      carry_o        <= 1'b0;
      dec_value_o    <= 8'h00;
      code_addr_o    <= '0;
      code_data_o    <= 8'h00;
      dptr_next_o    <= '0;
    end else if (finish) begin
      class_o        <= cls;
      branch_taken_o <= taken;
      next_pc_o      <= tgt;
      inst_len_o     <= len;
      cycles_o       <= cycles_of(cls);
      reg_sel_o      <= rsel;
      ret_addr_o     <= seq_pc;
      carry_o        <= cmp_lt;
      dec_value_o    <= dec_v;
      code_addr_o    <= dptr_q;
      code_data_o    <= acc_q;
      dptr_next_o    <= dptr_q + ADDR_W'(1);
    end
  end

  // Write strobes pulse with done_o only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      push_ret_o    <= 1'b0;
      pop_ret_o     <= 1'b0;
      irq_done_o    <= 1'b0;
      bit_clear_o   <= 1'b0;
      carry_write_o <= 1'b0;
      dec_write_o   <= 1'b0;
      code_write_o  <= 1'b0;
      dptr_write_o  <= 1'b0;
      trap_o        <= 1'b0;
    end else begin
      push_ret_o    <= finish && is_call;
      pop_ret_o     <= finish && is_ret;
      irq_done_o    <= finish && (cls == CL_RETI);
      bit_clear_o   <= finish && clr_bit;
      carry_write_o <= finish && is_cmp;
      dec_write_o   <= finish && is_dec;
      code_write_o  <= finish && is_store;
      dptr_write_o  <= finish && is_store;
      trap_o        <= finish && (cls == CL_TRAP);
    end
  end

endmodule : bid_branch_decode

// ### bid_consts.svh
`ifndef BID_CONSTS_SVH
`define BID_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcode values
// ----------------------------------------------------------------------
`define BID_OP_NOP        8'h00
`define BID_OP_LCALL      8'h12
`define BID_OP_RET        8'h22
`define BID_OP_RETI       8'h32
`define BID_OP_LJMP       8'h02
`define BID_OP_SJMP       8'h80
`define BID_OP_JC         8'h40
`define BID_OP_JNC        8'h50
`define BID_OP_JB         8'h20
`define BID_OP_JNB        8'h30
`define BID_OP_JBC        8'h10
`define BID_OP_JMPI       8'h73
`define BID_OP_JZ         8'h60
`define BID_OP_JNZ        8'h70
`define BID_OP_CJNE_AD    8'hb5
`define BID_OP_CJNE_AI    8'hb4
`define BID_OP_EXT        8'ha5

// Low five bits shared by the absolute call and jump code sets
`define BID_ABS_LOW_MASK  8'h1f
`define BID_ACALL_LOW     8'h11
`define BID_AJMP_LOW      8'h01

// Upper five bits of the eight-code register blocks, upper seven of @Ri
`define BID_CJNE_R_HI     5'h17
`define BID_DJNZ_R_HI     5'h1b
`define BID_CJNE_IND_HI   7'h5b
`define BID_DJNZ_D        8'hd5

// ----------------------------------------------------------------------
// Extended opcode select value that picks the program memory store
// ----------------------------------------------------------------------
`define BID_EO_STORE_SEL  4'h1

// ----------------------------------------------------------------------
// Instruction lengths and cycle counts
// ----------------------------------------------------------------------
`define BID_LEN_1         2'h1
`define BID_LEN_2         2'h2
`define BID_LEN_3         2'h3
`define BID_CYC_1         2'h1
`define BID_CYC_2         2'h2

`endif

// ### bid_pkg.sv
package bid_pkg;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } bid_state_t;

  // Decoded instruction class
  typedef enum logic [4:0] {
    CL_NONE     = 5'b00000,
    CL_NOP      = 5'b00001,
    CL_ACALL    = 5'b00010,
    CL_LCALL    = 5'b00011,
    CL_RET      = 5'b00100,
    CL_RETI     = 5'b00101,
    CL_AJMP     = 5'b00110,
    CL_LJMP     = 5'b00111,
    CL_SJMP     = 5'b01000,
    CL_JC       = 5'b01001,
    CL_JNC      = 5'b01010,
    CL_JB       = 5'b01011,
    CL_JNB      = 5'b01100,
    CL_JBC      = 5'b01101,
    CL_JMPI     = 5'b01110,
    CL_JZ       = 5'b01111,
    CL_JNZ      = 5'b10000,
    CL_CJNE_AD  = 5'b10001,
    CL_CJNE_AI  = 5'b10010,
    CL_CJNE_R   = 5'b10011,
    CL_CJNE_IND = 5'b10100,
    CL_DJNZ_R   = 5'b10101,
    CL_DJNZ_D   = 5'b10110,
    CL_PSTORE   = 5'b10111,
    CL_TRAP     = 5'b11000
  } bid_class_t;

endpackage : bid_pkg

// ### bid_pin_filter.sv
`timescale 1ns/1ps

module bid_pin_filter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("bid_pin_filter: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;

  // Three stages; only the second stage reads the first
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Accept a pin level only once stages two and three agree
  genvar gi;
  for (gi = 0; gi < WIDTH; gi++) begin : g_bit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        pin_o[gi] <= 1'b0;
      end else if (sync2[gi] == sync3[gi]) begin
        pin_o[gi] <= sync3[gi];
      end
    end
  end

endmodule : bid_pin_filter

// ### bid_branch_decode_monitor.sv
`timescale 1ns/1ps
module bid_chk
  import bid_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              start_i,
  input wire logic              busy_o,
  input wire logic              done_o,
  input bid_pkg::bid_class_t    class_o,
  input wire logic              branch_taken_o,
  input wire logic [1:0]        cycles_o,
  input wire logic              push_ret_o,
  input wire logic              bit_clear_o,
  input wire logic              code_write_o,
  input wire logic              dptr_write_o,
  input wire logic [ADDR_W-1:0] code_addr_o,
  input wire logic [ADDR_W-1:0] dptr_next_o,
  input wire logic              trap_o
);
  // ----------------------------------------------------------------
  // Handshake sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_take;
    start_i && !busy_o;
  endsequence
  sequence s_finish;
    ##[2:3] done_o;
  endsequence
  property p_answer;
    s_take |-> s_finish;
  endproperty
  // Requests and answers
  take_done_a: assert property (p_answer) else $error("no done after start");
  take_busy_a: assert property (s_take |=> busy_o) else $error("busy missing");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
  done_idle_a: assert property (done_o |-> !busy_o) else $error("busy at done");
  // Two-cycle classes keep busy for two run cycles, one-cycle ones do not
  cycle_count_a: assert property (done_o |-> ((cycles_o == 2'h2) == $past(busy_o, 2)))
    else $error("cycle count and timing disagree");
  // Side effects only with their class
  bit_clear_a: assert property (bit_clear_o |-> done_o && class_o == CL_JBC && branch_taken_o)
    else $error("bad bit clear");
  store_step_a: assert property (code_write_o |-> done_o && dptr_write_o
    && dptr_next_o == code_addr_o + 1'b1 && class_o == CL_PSTORE) else $error("bad store");
  trap_fast_a: assert property (trap_o |-> class_o == CL_TRAP && $past(start_i, 2))
    else $error("bad trap");
  push_ret_a: assert property (push_ret_o |-> done_o && (class_o == CL_ACALL
    || class_o == CL_LCALL)) else $error("bad push");
endmodule : bid_chk

bind bid_branch_decode bid_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### bid_branch_decode_tb_top.sv
`timescale 1ns/1ps
module bid_branch_decode_tb_top;
  import bid_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i, start_i, carry_i, bit_value_i, bit_is_port_i, direct_is_port_i;
  logic [7:0]  opcode_i, opnd1_i, opnd2_i, acc_i, direct_byte_i, reg_value_i, port_pin_i;
  logic [15:0] pc_i, dptr_i, stack_word_i;
  logic [3:0]  extended_opcode_select_i;
  logic        busy_o, done_o, branch_taken_o, push_ret_o, pop_ret_o, irq_done_o, trap_o;
  logic        bit_clear_o, carry_write_o, carry_o, dec_write_o, code_write_o, dptr_write_o;
  bid_class_t  class_o;
  logic [1:0]  inst_len_o, cycles_o;
  logic [2:0]  reg_sel_o;
  logic [7:0]  dec_value_o, code_data_o;
  logic [15:0] next_pc_o, ret_addr_o, code_addr_o, dptr_next_o;
  int          n_mismatch = 0;
  int          checks_done = 0;

  bid_branch_decode dut (.*);
  always #25 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  // Issue one instruction, wait a bounded time for done, check timing
  task automatic go(input logic [7:0] op, a, b, input logic [15:0] pc, input logic [1:0] c, l);
    int n;
    n = 0;
    @(posedge clk_i);
    opcode_i <= op;
    opnd1_i <= a;
    opnd2_i <= b;
    pc_i <= pc;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 4);
    chk(16'(n), 16'(c));
    chk(cycles_o, c);
    chk(inst_len_o, l);
  endtask : go

  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_abs;
    for (int i = 0; i < 8; i++) begin
      go({i[2:0], 5'h11}, 8'h5a, 8'h00, 16'h27fe, 2'h2, 2'h2);
      chk(next_pc_o, {5'h05, i[2:0], 8'h5a});
      chk(ret_addr_o, 16'h2800);
      chk(push_ret_o, 1'b1);
      go({i[2:0], 5'h01}, 8'h5a, 8'h00, 16'h27fe, 2'h2, 2'h2);
      chk(next_pc_o, {5'h05, i[2:0], 8'h5a});
      chk(push_ret_o, 1'b0);
    end
    go(8'h12, 8'h12, 8'h34, 16'h0100, 2'h2, 2'h3);
    chk(next_pc_o, 16'h1234);
    chk(ret_addr_o, 16'h0103);
  endtask : t_abs

  task automatic t_rel;
    go(8'h80, 8'hfe, 8'h00, 16'h0010, 2'h2, 2'h2);
    chk(next_pc_o, 16'h0010);
    go(8'h60, 8'h10, 8'h00, 16'h0010, 2'h2, 2'h2);
    chk(next_pc_o, 16'h0022);
    go(8'h70, 8'h10, 8'h00, 16'h0010, 2'h2, 2'h2);
    chk(next_pc_o, 16'h0012);
    chk(branch_taken_o, 1'b0);
    go(8'h73, 8'h00, 8'h00, 16'h0010, 2'h2, 2'h1);
    chk(next_pc_o, 16'h1000);
    @(posedge clk_i);
    {carry_i, stack_word_i} <= {1'b1, 16'h4321};
    go(8'h40, 8'h10, 8'h00, 16'h0010, 2'h2, 2'h2);
    chk(next_pc_o, 16'h0022);
    go(8'h32, 8'h00, 8'h00, 16'h0010, 2'h2, 2'h1);
    chk(next_pc_o, 16'h4321);
    chk({pop_ret_o, irq_done_o, push_ret_o}, 3'h6);
    go(8'h00, 8'h00, 8'h00, 16'h0010, 2'h1, 2'h1);
    chk(class_o, CL_NOP);
  endtask : t_rel

  task automatic t_bit;
    @(posedge clk_i);
    bit_value_i <= 1'b1;
    go(8'h20, 8'h21, 8'h04, 16'h0100, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0107);
    chk(bit_clear_o, 1'b0);
    go(8'h30, 8'h21, 8'h04, 16'h0100, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0103);
    go(8'h10, 8'h21, 8'h04, 16'h0100, 2'h2, 2'h3);
    chk(bit_clear_o, 1'b1);
    chk(next_pc_o, 16'h0107);
  endtask : t_bit

  // Port operands once the pins have settled through the filter
  task automatic t_port;
    @(posedge clk_i);
    port_pin_i <= 8'h24;
    {bit_is_port_i, direct_is_port_i, bit_value_i} <= 3'h6;
    repeat (6) @(posedge clk_i);
    go(8'h20, 8'h05, 8'h04, 16'h0100, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0107);
    go(8'hd5, 8'h80, 8'h02, 16'h0300, 2'h2, 2'h3);
    chk(dec_value_o, 8'h23);
    @(posedge clk_i);
    {bit_is_port_i, bit_value_i} <= {1'b0, port_pin_i[5]};
    go(8'h20, 8'h05, 8'h04, 16'h0100, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0107);
  endtask : t_port

  task automatic t_cmp;
    @(posedge clk_i);
    acc_i <= 8'h33;
    go(8'hb5, 8'h40, 8'h20, 16'h0200, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0203);
    go(8'hb4, 8'h34, 8'h80, 16'h0200, 2'h2, 2'h3);
    chk(next_pc_o, 16'h0183);
    chk({carry_write_o, carry_o}, 2'h3);
    for (int i = 0; i < 8; i++) begin
      go({5'h17, i[2:0]}, 8'h07, 8'h10, 16'h0200, 2'h2, 2'h3);
      chk(reg_sel_o, i[2:0]);
      chk(next_pc_o, 16'h0203);
      go({5'h1b, i[2:0]}, 8'h10, 8'h00, 16'h0200, 2'h2, 2'h2);
      chk({dec_write_o, reg_sel_o, dec_value_o}, {1'b1, i[2:0], 8'h06});
      chk(next_pc_o, 16'h0212);
      go({7'h5b, i[0]}, 8'h09, 8'h10, 16'h0200, 2'h2, 2'h3);
      chk(reg_sel_o, {2'h0, i[0]});
    end
    go(8'hd5, 8'h40, 8'h02, 16'h0300, 2'h2, 2'h3);
    chk({dec_value_o, 8'h00}, {8'h32, 8'h00});
    chk(next_pc_o, 16'h0305);
  endtask : t_cmp

  task automatic t_ext;
    @(posedge clk_i);
    acc_i <= 8'h5c;
    dptr_i <= 16'hfff0;
    go(8'ha5, 8'h00, 8'h00, 16'h0400, 2'h2, 2'h1);
    chk({code_write_o, dptr_write_o, code_data_o}, {2'h3, 8'h5c});
    chk(code_addr_o, 16'hfff0);
    chk(dptr_next_o, 16'hfff1);
    @(posedge clk_i);
    extended_opcode_select_i <= 4'h2;
    go(8'ha5, 8'h00, 8'h00, 16'h0400, 2'h1, 2'h1);
    chk({trap_o, code_write_o}, 2'h2);
    chk(class_o, CL_TRAP);
  endtask : t_ext

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {sys_rst_i, extended_opcode_select_i} = 5'h11;
    {start_i, carry_i, bit_value_i, bit_is_port_i, direct_is_port_i} = 5'h00;
    {opcode_i, opnd1_i, opnd2_i, acc_i, port_pin_i} = 40'h0;
    {direct_byte_i, reg_value_i} = 16'h3307;
    {pc_i, dptr_i, stack_word_i} = {32'h0000_1000, 16'h0000};
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(class_o, CL_NONE);
    chk({busy_o, done_o}, 2'h0);
    t_abs();
    t_rel();
    t_bit();
    t_cmp();
    t_ext();
    t_port();
    stop_test();
  end

  // Full run needs roughly 12 us, so 200 us only trips on a hang
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : bid_branch_decode_tb_top
